// *** src/tssc_top.sv ***
// Purpose: start source choice, two-step start, key lock, interlock and
//          pass/fail output shaping of a bench tester
// Assumes: pins are active high after the synchroniser; judgment and
//          end of test come from software through the command register
// Notes:   all outputs registered
// Contract
// - accept starts only from chosen source
// - single step: start press in ready starts
// - two-step: stop then start within 500ms
// - remote interface ignores two-step option
// - key lock rejects parameter changing keys
// - interlock on: run only when loop shorted
// - open interlock start: flag, no start
// - no extension: judgment output held low
// - extension: low pulse cut plus buzzer time
// - remote source: starts only from remote
// - test active output while testing
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none
`include "tssc_defines.svh"
module tssc_top #(
  parameter int unsigned DBL_CYC = `TSSC_DBL_CYC, // two-step window
  parameter int unsigned MS_CYC  = `TSSC_MS_CYC   // cycles per ms
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // axi4-lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // pins (active high)
  input  wire logic        i_panel_start,
  input  wire logic        i_panel_stop,
  input  wire logic        i_rmt_start,
  input  wire logic        i_rmt_stop,
  input  wire logic        i_sio_start,
  input  wire logic        i_sio_stop,
  input  wire logic        i_ilock_short,   // loop closed
  input  wire logic        i_key_param,     // parameter-changing key
  // outputs
  output logic             o_test_active,
  output logic             o_pass_n,
  output logic             o_fail_n,
  output logic             o_key_accept,    // one-cycle pulse
  output logic             o_ilock_open,    // open indication level
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] pin_s;   // synchronised pins
  tssc_sync #(.W(8)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_key_param, i_ilock_short, i_sio_stop, i_sio_start,
                i_rmt_stop, i_rmt_start, i_panel_stop, i_panel_start}),
    .o_sync   (pin_s)
  );
  logic [7:0] pin_d_r;  // previous level for edges
  logic [7:0] rise;     // press edges
  assign rise = pin_s & ~pin_d_r;

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0]            ctrl_r, ctrl_nxt;     // control fields
  logic [15:0]           cut_r, cut_nxt;       // cut time, ms
  logic [15:0]           pbz_r, pbz_nxt;       // pass buzzer, ms
  logic [15:0]           fbz_r, fbz_nxt;       // fail buzzer, ms
  logic [`TSSC_NEV-1:0]  ist_r, ist_nxt;       // sticky events
  logic [`TSSC_NEV-1:0]  ien_r, ien_nxt;       // event enables
  logic [`TSSC_NEV-1:0]  ev;                   // event pulses
  logic [`TSSC_NEV-1:0]  iclr;                 // clear pulses
  logic                  aw_r, aw_nxt;         // address held
  logic                  w_r, w_nxt;           // data held
  logic [7:0]            awa_r, awa_nxt;
  logic [31:0]           wd_r, wd_nxt;
  logic                  bv_r, bv_nxt;
  logic [1:0]            br_r, br_nxt;
  logic                  rv_r, rv_nxt;
  logic [31:0]           rd_r, rd_nxt;
  logic [1:0]            rr_r, rr_nxt;
  logic                  wr_go;                // write commit
  logic [2:0]            cmd;                  // command pulses
  tssc_pkg::tssc_state_e st_r, st_nxt;           // run state
  logic                  dbl_arm_r, dbl_arm_nxt; // stop seen, window open
  logic [31:0]           dbl_cnt_r, dbl_cnt_nxt; // window countdown
  logic                  ilock_open_r, ilock_open_nxt; // refused start flag
  logic                  start_p, stop_p, go, ilock_ok, dbl_mode;

  tssc_pkg::tssc_src_e   src;
  assign src = tssc_pkg::tssc_src_e'(ctrl_r[`TSSC_SRC_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////
  // bus slave next state
  always_comb begin
    aw_nxt = aw_r; w_nxt = w_r; awa_nxt = awa_r; wd_nxt = wd_r;
    bv_nxt = bv_r; br_nxt = br_r; rv_nxt = rv_r; rd_nxt = rd_r;
    rr_nxt = rr_r; ctrl_nxt = ctrl_r; cut_nxt = cut_r;
    pbz_nxt = pbz_r; fbz_nxt = fbz_r; ien_nxt = ien_r;
    iclr = '0; cmd = '0; wr_go = 1'b0;
    // take address and data in either order
    if (i_awvalid && !aw_r && !bv_r) begin
      aw_nxt = 1'b1; awa_nxt = i_awaddr;
    end
    if (i_wvalid && !w_r && !bv_r) begin
      w_nxt = 1'b1; wd_nxt = i_wdata;
    end
    if (aw_r && w_r) begin
      wr_go = 1'b1; aw_nxt = 1'b0; w_nxt = 1'b0;
      bv_nxt = 1'b1; br_nxt = `TSSC_RESP_OKAY;
      if (awa_r == `TSSC_CTRL_OFS) begin
        ctrl_nxt = wd_r[6:0];
      end else if (awa_r == `TSSC_CUT_OFS) begin
        cut_nxt = wd_r[15:0];
      end else if (awa_r == `TSSC_PASSBZ_OFS) begin
        pbz_nxt = wd_r[15:0];
      end else if (awa_r == `TSSC_FAILBZ_OFS) begin
        fbz_nxt = wd_r[15:0];
      end else if (awa_r == `TSSC_IRQ_EN_OFS) begin
        ien_nxt = wd_r[`TSSC_NEV-1:0];
      end else if (awa_r == `TSSC_IRQ_CLR_OFS) begin
        iclr = wd_r[`TSSC_NEV-1:0];
      end else if (awa_r == `TSSC_CMD_OFS) begin
        cmd = wd_r[2:0];
      end else if (awa_r != `TSSC_STAT_OFS && awa_r != `TSSC_IRQ_ST_OFS)
      begin
        br_nxt = `TSSC_RESP_SLVERR;
      end
    end
    if (bv_r && i_bready) begin
      bv_nxt = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (rv_r && i_rready) begin
      rv_nxt = 1'b0;
    end
    if (i_arvalid && !rv_r) begin
      rv_nxt = 1'b1; rr_nxt = `TSSC_RESP_OKAY; rd_nxt = 32'h0000_0000;
      if (i_araddr == `TSSC_CTRL_OFS) begin
        rd_nxt[6:0] = ctrl_r;
      end else if (i_araddr == `TSSC_CUT_OFS) begin
        rd_nxt[15:0] = cut_r;
      end else if (i_araddr == `TSSC_PASSBZ_OFS) begin
        rd_nxt[15:0] = pbz_r;
      end else if (i_araddr == `TSSC_FAILBZ_OFS) begin
        rd_nxt[15:0] = fbz_r;
      end else if (i_araddr == `TSSC_STAT_OFS) begin
        rd_nxt[4:0] = {dbl_arm_r, ilock_open_r, o_test_active,
                       2'(st_r)};
        rd_nxt[6]   = ~ctrl_r[`TSSC_ILOCK_BIT] | pin_s[6];
      end else if (i_araddr == `TSSC_IRQ_ST_OFS) begin
        rd_nxt[`TSSC_NEV-1:0] = ist_r;
      end else if (i_araddr == `TSSC_IRQ_EN_OFS) begin
        rd_nxt[`TSSC_NEV-1:0] = ien_r;
      end else if (i_araddr != `TSSC_IRQ_CLR_OFS &&
                   i_araddr != `TSSC_CMD_OFS) begin
        rr_nxt = `TSSC_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // start control
  always_comb begin
    st_nxt = st_r; dbl_arm_nxt = dbl_arm_r; dbl_cnt_nxt = dbl_cnt_r;
    ilock_open_nxt = ilock_open_r; ev = '0; go = 1'b0;
    // only the chosen source feeds the starts
    case (src)
      tssc_pkg::TSSC_SRC_REMOTE: start_p = rise[2];
      tssc_pkg::TSSC_SRC_SIGIO:  start_p = rise[4];
      default:                   start_p = rise[0];
    endcase
    // panel stop always works; other stops only from chosen source
    stop_p = rise[1] | (src == tssc_pkg::TSSC_SRC_REMOTE & rise[3])
           | (src == tssc_pkg::TSSC_SRC_SIGIO & rise[5]);
    // remote interface overrides two-step
    dbl_mode = ctrl_r[`TSSC_DBL_BIT] & ~ctrl_r[`TSSC_REMIF_BIT];
    ilock_ok = ~ctrl_r[`TSSC_ILOCK_BIT] | pin_s[6];
    // two-step window timer
    if (dbl_arm_r) begin
      if (dbl_cnt_r == 32'd1) begin
        dbl_arm_nxt = 1'b0;
      end
      dbl_cnt_nxt = dbl_cnt_r - 32'd1;
    end
    case (st_r)
      tssc_pkg::TSSC_READY: begin
        if (stop_p) begin
          dbl_arm_nxt = 1'b1;
          dbl_cnt_nxt = DBL_CYC;
        end else if (start_p && (!dbl_mode || dbl_arm_r)) begin
          dbl_arm_nxt = 1'b0;
          if (!ilock_ok) begin
            ilock_open_nxt = 1'b1;
            ev[`TSSC_EV_ILOCK] = 1'b1;
          end else begin
            go = 1'b1;
            ilock_open_nxt = 1'b0;
            st_nxt = tssc_pkg::TSSC_TESTING;
            ev[`TSSC_EV_START] = 1'b1;
          end
        end
      end
      tssc_pkg::TSSC_TESTING: begin
        // starts here are ignored
        if (stop_p || cmd[`TSSC_CMD_END_BIT] || !ilock_ok) begin
          st_nxt = tssc_pkg::TSSC_READY;
        end else if (cmd[`TSSC_CMD_PASS_BIT] || cmd[`TSSC_CMD_FAIL_BIT])
        begin
          st_nxt = tssc_pkg::TSSC_JUDGED;
          ev[`TSSC_EV_JUDGE] = 1'b1;
        end
      end
      default: begin
        // judged: stop returns to ready; starts ignored
        if (stop_p) begin
          st_nxt = tssc_pkg::TSSC_READY;
        end
      end
    endcase
    if (rise[7] && ctrl_r[`TSSC_KEYLOCK_BIT]) begin
      ev[`TSSC_EV_KEYREJ] = 1'b1;
    end
    // sticky events: set wins over clear
    ist_nxt = (ist_r & ~iclr) | ev;
  end

  ////////////////////////////////////////////////////////////////////
  // judgment output shaping
  logic        pass_n_r, pass_n_nxt, fail_n_r, fail_n_nxt;
  logic [16:0] pms_r, pms_nxt;          // pulse length left, ms
  logic [31:0] msc_r, msc_nxt;          // ms prescaler
  logic        judge, is_fail;
  assign judge   = st_r == tssc_pkg::TSSC_TESTING &&
                   (cmd[`TSSC_CMD_PASS_BIT] || cmd[`TSSC_CMD_FAIL_BIT]) &&
                   !stop_p && !cmd[`TSSC_CMD_END_BIT] && ilock_ok;
  assign is_fail = cmd[`TSSC_CMD_FAIL_BIT];

  always_comb begin
    pass_n_nxt = pass_n_r; fail_n_nxt = fail_n_r;
    pms_nxt = pms_r; msc_nxt = msc_r;
    if (go) begin
      pass_n_nxt = 1'b1; fail_n_nxt = 1'b1; pms_nxt = '0;
    end else if (judge) begin
      pass_n_nxt = is_fail;
      fail_n_nxt = !is_fail;
      msc_nxt = MS_CYC;
      // pulse spans cut time plus buzzer time
      pms_nxt = ctrl_r[`TSSC_PEXT_BIT] ?
        ({1'b0, cut_r} + {1'b0, is_fail ? fbz_r : pbz_r}) : 17'd0;
    end else if (ctrl_r[`TSSC_PEXT_BIT] && pms_r != '0) begin
      if (msc_r <= 32'd1) begin
        msc_nxt = MS_CYC;
        pms_nxt = pms_r - 17'd1;
        if (pms_r == 17'd1) begin
          pass_n_nxt = 1'b1;
          fail_n_nxt = 1'b1;
        end
      end else begin
        msc_nxt = msc_r - 32'd1;
      end
    end else if (ctrl_r[`TSSC_PEXT_BIT] && st_r == tssc_pkg::TSSC_JUDGED)
    begin
      pass_n_nxt = 1'b1;                 // zero-length pulse ends at once
      fail_n_nxt = 1'b1;
    end
    // otherwise the level stays low until next start
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_d_r <= '0; ctrl_r <= '0; cut_r <= '0; pbz_r <= '0;
      fbz_r <= '0; ist_r <= '0; ien_r <= '0; aw_r <= 1'b0; w_r <= 1'b0;
      awa_r <= '0; wd_r <= '0; bv_r <= 1'b0; br_r <= '0; rv_r <= 1'b0;
      rd_r <= '0; rr_r <= '0; st_r <= tssc_pkg::TSSC_READY;
      dbl_arm_r <= 1'b0; dbl_cnt_r <= '0; ilock_open_r <= 1'b0;
      pass_n_r <= 1'b1; fail_n_r <= 1'b1; pms_r <= '0; msc_r <= '0;
      o_key_accept <= 1'b0; o_irq <= 1'b0; o_test_active <= 1'b0;
      o_awready <= 1'b1; o_wready <= 1'b1; o_arready <= 1'b1;
    end else begin
      pin_d_r <= pin_s; ctrl_r <= ctrl_nxt; cut_r <= cut_nxt;
      pbz_r <= pbz_nxt; fbz_r <= fbz_nxt; ist_r <= ist_nxt;
      ien_r <= ien_nxt; aw_r <= aw_nxt; w_r <= w_nxt; awa_r <= awa_nxt;
      wd_r <= wd_nxt; bv_r <= bv_nxt; br_r <= br_nxt; rv_r <= rv_nxt;
      rd_r <= rd_nxt; rr_r <= rr_nxt; st_r <= st_nxt;
      dbl_arm_r <= dbl_arm_nxt; dbl_cnt_r <= dbl_cnt_nxt;
      ilock_open_r <= ilock_open_nxt; pass_n_r <= pass_n_nxt;
      fail_n_r <= fail_n_nxt; pms_r <= pms_nxt; msc_r <= msc_nxt;
      o_key_accept <= rise[7] & ~ctrl_r[`TSSC_KEYLOCK_BIT];
      o_irq <= |(ist_nxt & ien_nxt);
      // readies and test active registered from the next state
      o_awready <= !aw_nxt && !bv_nxt;
      o_wready <= !w_nxt && !bv_nxt;
      o_arready <= !rv_nxt;
      o_test_active <= st_nxt == tssc_pkg::TSSC_TESTING;
    end
  end

  assign o_bvalid      = bv_r;
  assign o_bresp       = br_r;
  assign o_rvalid      = rv_r;
  assign o_rdata       = rd_r;
  assign o_rresp       = rr_r;
  assign o_pass_n      = pass_n_r;
  assign o_fail_n      = fail_n_r;
  assign o_ilock_open  = ilock_open_r;

  ////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_ready_start;
    st_r == tssc_pkg::TSSC_READY && start_p && !stop_p;
  endsequence

  a_src_only: assert property (st_r == tssc_pkg::TSSC_READY &&
    !start_p |=> st_r == tssc_pkg::TSSC_READY)
    else $error("start taken without a chosen-source press");
  a_single_start: assert property (s_ready_start and ##0
    (!dbl_mode && ilock_ok) |=> o_test_active)
    else $error("single step start did not begin a test");
  a_double_need: assert property (s_ready_start and ##0
    (dbl_mode && !dbl_arm_r) |=> !o_test_active)
    else $error("two-step start began without stop");
  a_remote_if: assert property (ctrl_r[`TSSC_REMIF_BIT] |->
    !dbl_mode) else $error("two-step active under remote interface");
  a_key_lock: assert property (ctrl_r[`TSSC_KEYLOCK_BIT] &&
    rise[7] |=> !o_key_accept && ist_r[`TSSC_EV_KEYREJ])
    else $error("locked key accepted");
  a_ilock_run: assert property (o_test_active &&
    ctrl_r[`TSSC_ILOCK_BIT] && !pin_s[6] |=> !o_test_active)
    else $error("test kept running with loop open");
  a_ilock_flag: assert property (s_ready_start and ##0
    (!ilock_ok && (!dbl_mode || dbl_arm_r)) |=> o_ilock_open &&
    !o_test_active) else $error("open loop start not refused");
  a_level_hold: assert property (!ctrl_r[`TSSC_PEXT_BIT] &&
    judge && !is_fail ##1 !go [*2] |-> !o_pass_n)
    else $error("pass level not held low");
  a_pulse_end: assert property (ctrl_r[`TSSC_PEXT_BIT] &&
    pms_r == 17'd1 && msc_r <= 32'd1 && !go && !judge |=>
    o_pass_n && o_fail_n) else $error("pulse did not end on time");
  a_active_out: assert property (go |=> o_test_active)
    else $error("test active not raised");
  a_busy_ignore: assert property (
    st_r == tssc_pkg::TSSC_JUDGED && !stop_p |=>
    st_r == tssc_pkg::TSSC_JUDGED)
    else $error("judged state left without stop");
endmodule : tssc_top
`default_nettype wire

// *** src/tssc_defines.svh ***
// Purpose: constants of the test start and safety control block
// Assumes: 50 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   offsets are byte addresses of aligned words
`ifndef TSSC_DEFINES_SVH
`define TSSC_DEFINES_SVH

// register byte offsets
`define TSSC_CTRL_OFS     8'h00
`define TSSC_CUT_OFS      8'h04
`define TSSC_PASSBZ_OFS   8'h08
`define TSSC_FAILBZ_OFS   8'h0C
`define TSSC_STAT_OFS     8'h10
`define TSSC_IRQ_ST_OFS   8'h14
`define TSSC_IRQ_EN_OFS   8'h18
`define TSSC_IRQ_CLR_OFS  8'h1C
`define TSSC_CMD_OFS      8'h20

// control register fields
`define TSSC_SRC_LSB      0
`define TSSC_DBL_BIT      2
`define TSSC_KEYLOCK_BIT  3
`define TSSC_ILOCK_BIT    4
`define TSSC_PEXT_BIT     5
`define TSSC_REMIF_BIT    6

// command register fields (write pulses)
`define TSSC_CMD_PASS_BIT 0
`define TSSC_CMD_FAIL_BIT 1
`define TSSC_CMD_END_BIT  2

// interrupt status bits
`define TSSC_EV_START     0
`define TSSC_EV_ILOCK     1
`define TSSC_EV_KEYREJ    2
`define TSSC_EV_JUDGE     3
`define TSSC_NEV          4

// timing
`define TSSC_CLK_MHZ      50
`define TSSC_DBL_MS       500
`define TSSC_DBL_CYC      (`TSSC_DBL_MS * 1000 * `TSSC_CLK_MHZ)
`define TSSC_MS_CYC       (1000 * `TSSC_CLK_MHZ)

// axi responses
`define TSSC_RESP_OKAY    2'b00
`define TSSC_RESP_SLVERR  2'b10

`endif

// *** src/tssc_pkg.sv ***
// Purpose: types of the test start and safety control block
// Assumes: nothing beyond the defines header
// Notes:   nothing is imported; uses are scoped
`default_nettype none
package tssc_pkg;
  // start source choice
  typedef enum logic [1:0] {
    TSSC_SRC_PANEL,
    TSSC_SRC_REMOTE,
    TSSC_SRC_SIGIO
  } tssc_src_e;
  // tester run state
  typedef enum logic [1:0] {
    TSSC_READY,
    TSSC_TESTING,
    TSSC_JUDGED
  } tssc_state_e;
endpackage : tssc_pkg
`default_nettype wire

// *** src/tssc_sync.sv ***
// Purpose: three-flop synchroniser with agreement filter, per bit
// Assumes: inputs come from pins outside the clock domain
// Notes:   output changes once stage two and three agree
`default_nettype none
module tssc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1_r;   // first stage, read only by s2
  logic [W-1:0] s2_r;   // second stage
  logic [W-1:0] s3_r;   // third stage
  logic [W-1:0] out_r;  // filtered level
  logic [W-1:0] out_nxt;

  ////////////////////////////////////////////////////////////////////
  // agreement filter per bit
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s2_r[i];
      end
    end
  end

  // stages
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= i_async;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign o_sync = out_r;
endmodule : tssc_sync
`default_nettype wire

// *** verif/tssc_op_model.sv ***
// Purpose: operator side model: panel, remote and signal io buttons
// Assumes: pins active high, low when released
// Notes:   each press is held long enough to pass the input filter
`default_nettype none
module tssc_op_model (
  input  wire logic       i_clk,
  output logic      [2:0] o_start, // panel, remote, signal io
  output logic      [2:0] o_stop,  // same order as o_start
  output logic            o_ilock, // high while the loop is closed
  output logic            o_key    // parameter key
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: nothing pressed, loop closed
  initial begin
    o_start = 3'h0;
    o_stop  = 3'h0;
    o_ilock = 1'b1;
    o_key   = 1'b0;
  end

  ////////////////////////////////////////
  // one press, k == 3 is the parameter key; released pins fall low
  task automatic press(input logic stp, input int k, input int hold);
    @(posedge i_clk);
    if (k == 3) begin
      o_key <= 1'b1;
    end else if (stp) begin
      o_stop[k] <= 1'b1;
    end else begin
      o_start[k] <= 1'b1;
    end
    repeat (hold) @(posedge i_clk);
    o_start <= 3'h0;
    o_stop  <= 3'h0;
    o_key   <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : press

  // stop then start at once, well inside the two-step window
  task automatic dbl_press(input int k, input int hold);
    press(1'b1, k, hold);
    press(1'b0, k, hold);
  endtask : dbl_press

  // open or close the loop and let the filter settle
  task automatic set_ilock(input logic v);
    @(posedge i_clk);
    o_ilock <= v;
    repeat (6) @(posedge i_clk);
  endtask : set_ilock
endmodule : tssc_op_model
`default_nettype wire

// *** verif/tssc_top_tb_top.sv ***
// Purpose: self-checking bench of the start and safety control block
// Assumes: short two-step window and millisecond count
// Notes:   expectations come from the settings the bench wrote
`default_nettype none
`include "tssc_defines.svh"
module tssc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DBL = 50; // two-step window in cycles
  localparam int MS  = 5;  // cycles per ms
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  i_awaddr = 8'h00;
  logic [7:0]  i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0;
  logic [2:0]  st, sp;     // start and stop pins
  logic        ilk, key;   // loop closed, parameter key
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic        o_test_active, o_pass_n, o_fail_n, o_key_accept;
  logic        o_ilock_open, o_irq;
  int          n_fail = 0, comparisons = 0, cycles = 0;
  int          seed = 73696;
  int          pass_lo = 0, fail_lo = 0, acc = 0; // observed counts

  always #10 i_clk = ~i_clk;

  tssc_op_model op_u (.i_clk(i_clk), .o_start(st), .o_stop(sp),
    .o_ilock(ilk), .o_key(key));

  tssc_top #(.DBL_CYC(DBL), .MS_CYC(MS)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_panel_start(st[0]), .i_panel_stop(sp[0]),
    .i_rmt_start(st[1]), .i_rmt_stop(sp[1]),
    .i_sio_start(st[2]), .i_sio_stop(sp[2]),
    .i_ilock_short(ilk), .i_key_param(key),
    .o_test_active(o_test_active), .o_pass_n(o_pass_n),
    .o_fail_n(o_fail_n), .o_key_accept(o_key_accept),
    .o_ilock_open(o_ilock_open), .o_irq(o_irq));

  ////////////////////////////////////////
  // observed counts and the hang limit
  always @(posedge i_clk) begin
    cycles++;
    if (!o_pass_n) pass_lo++;
    if (!o_fail_n) fail_lo++;
    if (o_key_accept) acc++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    {i_awvalid, i_wvalid, i_bready} <= 3'b111;
    do begin
      @(posedge i_clk);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid && n < 100);
    chk(o_bvalid, 1'b1);
    chk(o_bresp, `TSSC_RESP_OKAY);
    i_bready <= 1'b0;
  endtask : wr

  // read: rready held from the start until rvalid is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'b11;
    do begin
      @(posedge i_clk);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid && n < 100);
    chk(o_rvalid, 1'b1);
    v = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask : rd

  // one press with a random hold length
  task automatic pr(input logic stp, input int k);
    op_u.press(stp, k, 6 + $unsigned($random(seed)) % 4);
  endtask : pr

  ////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    // registers: reset value, read back, unmapped place
    rd(`TSSC_CTRL_OFS, v, r);
    chk(v, 32'h0000_0000);
    d = $unsigned($random(seed)) & 32'h0000_FFFF;
    wr(`TSSC_CUT_OFS, d);
    rd(`TSSC_CUT_OFS, v, r);
    chk(v, d);
    rd(8'h40, v, r);
    chk(r, `TSSC_RESP_SLVERR);
    // key lock refuses, then accepts once lifted
    wr(`TSSC_CTRL_OFS, 32'h0000_0008);
    acc = 0;
    pr(0, 3);
    chk(acc, 0);
    wr(`TSSC_CTRL_OFS, 32'h0000_0000);
    pr(0, 3);
    chk(acc, 1);
    $display("done keys and registers");
    // every source against every chosen source
    for (int s = 0; s < 3; s++) begin
      wr(`TSSC_CTRL_OFS, s);
      for (int k = 0; k < 3; k++) begin
        pr(0, k);
        chk(o_test_active, k == s);
        pr(0, k);
        chk(o_test_active, k == s);
        pr(1, 0);
        chk(o_test_active, 1'b0);
      end
    end
    $display("done sources");
    // two-step: single press, ordered pair, late start, remote control
    wr(`TSSC_CTRL_OFS, 32'h0000_0004);
    repeat (DBL + 20) @(posedge i_clk);
    pr(0, 0);
    chk(o_test_active, 1'b0);
    op_u.dbl_press(0, 7);
    chk(o_test_active, 1'b1);
    pr(1, 0);
    pr(1, 0);
    repeat (DBL + 20) @(posedge i_clk);
    pr(0, 0);
    chk(o_test_active, 1'b0);
    wr(`TSSC_CTRL_OFS, 32'h0000_0044);
    pr(0, 0);
    chk(o_test_active, 1'b1);
    pr(1, 0);
    $display("done two-step");
    // interlock open refuses and flags, closed loop runs
    wr(`TSSC_CTRL_OFS, 32'h0000_0010);
    wr(`TSSC_IRQ_EN_OFS, 32'h0000_0002);
    op_u.set_ilock(1'b0);
    pr(0, 0);
    chk(o_test_active, 1'b0);
    chk(o_ilock_open, 1'b1);
    chk(o_irq, 1'b1);
    wr(`TSSC_IRQ_CLR_OFS, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1'b0);
    op_u.set_ilock(1'b1);
    pr(0, 0);
    chk(o_test_active, 1'b1);
    chk(o_ilock_open, 1'b0);
    $display("done interlock");
    // level judgment, then a timed pulse of cut plus buzzer
    wr(`TSSC_CTRL_OFS, 32'h0000_0000);
    pass_lo = 0;
    fail_lo = 0;
    wr(`TSSC_CMD_OFS, 32'h0000_0001);
    repeat (100) @(posedge i_clk);
    chk(pass_lo >= 100, 1'b1);
    chk(fail_lo, 0);
    chk(o_test_active, 1'b0);
    pr(0, 0);
    chk(o_pass_n, 1'b0);
    pr(1, 0);
    pr(0, 0);
    chk(o_pass_n, 1'b1);
    chk(o_test_active, 1'b1);
    wr(`TSSC_CTRL_OFS, 32'h0000_0020);
    wr(`TSSC_CUT_OFS, 32'h0000_0002);
    wr(`TSSC_FAILBZ_OFS, 32'h0000_0003);
    fail_lo = 0;
    wr(`TSSC_CMD_OFS, 32'h0000_0002);
    repeat (100) @(posedge i_clk);
    chk(fail_lo, (2 + 3) * MS);
    chk(o_fail_n, 1'b1);
    $display("done judgment");
    give_verdict();
  end
endmodule : tssc_top_tb_top
`default_nettype wire
